// ==== core/vro_pkg.sv ====
// constants for the video receiver output port
package vro_pkg;

   // =======================================================
   // register map (byte addresses)
   localparam logic [11:0] CTRL_OFF        = 12'h000;
   localparam logic [11:0] STAT_OFF        = 12'h004;

   // =======================================================
   // field positions and reset values
   localparam int          CTRL_SWPD_BIT   = 0;
   localparam logic        CTRL_SWPD_RST   = 1'b0;
   localparam int          STAT_ALIVE_BIT  = 0;
   localparam int          STAT_CPD_BIT    = 1;
   localparam int          STAT_FLOAT_BIT  = 2;
   localparam int          PIX_W           = 24;

   // =======================================================
   // link-alive timing
   localparam logic [4:0]  ALIVE_EDGES     = 5'h19;
   localparam longint      LOSS_TIME_MS    = 64'd100;
   localparam longint      LINK_PERIOD_PS  = 64'd30000;
   localparam longint      LOSS_TIME_PS    = LOSS_TIME_MS * 64'd1000000000;
   localparam logic [21:0] LOSS_CYCLES     =
      22'(LOSS_TIME_PS / LINK_PERIOD_PS);

endpackage

// ==== core/vro_alive_if.sv ====
// link-alive detector hookup
`timescale 1ns/100ps
interface vro_alive_if;
   logic de;
   logic alive;
   modport det  (input de, output alive);
   modport user (output de, input alive);
endinterface

// ==== core/vro_alive_det.sv ====
// link-alive detector watching the active-video flag
`timescale 1ns/100ps
module vro_alive_det #(
   parameter logic [21:0] LOSS_CYCLES = vro_pkg::LOSS_CYCLES
) (
   // clock and reset
   input  wire logic      clk,
   input  wire logic      rst_n,
   // detector port
   vro_alive_if.det       bus
);

   typedef struct packed {
      logic        de_prev;
      logic [4:0]  edges;
      logic [21:0] idle;
      logic        alive;
   } vro_alive_st_t;

   vro_alive_st_t st_q;
   vro_alive_st_t st_d;
   logic          de_rise;

   // =======================================================
   // edge counting and idle timeout
   always_comb begin
      st_d         = st_q;
      de_rise      = bus.de & ~st_q.de_prev;
      st_d.de_prev = bus.de;
      if (de_rise) begin
         st_d.idle = 22'h000000;
         if (st_q.edges != vro_pkg::ALIVE_EDGES) begin
            st_d.edges = st_q.edges + 5'h01;
         end
         if (st_q.edges >= vro_pkg::ALIVE_EDGES - 5'h01) begin
            st_d.alive = 1'b1;
         end
      end else if (st_q.idle >= LOSS_CYCLES - 22'h000001) begin
         st_d.alive = 1'b0;
         st_d.edges = 5'h00;
      end else begin
         st_d.idle = st_q.idle + 22'h000001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.alive = st_q.alive;

   // =======================================================
   // checks
   a_alive_lost: assert property (@(posedge clk) disable iff (!rst_n)
      (!de_rise && st_q.idle >= LOSS_CYCLES - 22'h000001) |=> !st_q.alive)
      else $error("link alive not dropped after idle timeout");

   a_alive_gain: assert property (@(posedge clk) disable iff (!rst_n)
      (de_rise && st_q.edges == vro_pkg::ALIVE_EDGES - 5'h01)
      |=> st_q.alive)
      else $error("link alive not raised after enough edges");

endmodule // vro_alive_det

// ==== core/vro_out_port.sv ====
// video receiver output port with apb status and control
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps

//
// Overview of operation
// - separate 24-bit even and odd pixel buses
// - both buses update on output clock
// - either power-down floats pixel bus drivers
// - floated outputs are driven weakly low
// - output clock invertible; power-down floats it
// - active-video flag high active, low blanking
// - active-video flag aligned with pixel words
// - output power-down leaves first control driven
// - syncs, control two, three float on either
// - polarity changes clock only, not data timing
// - output power-down keeps alive flag, control one
// - chip power-down floats all but alive flag, disables inputs
// - alive flag follows flag activity, always driven
module vro_out_port #(
   parameter logic [21:0] LOSS_CYCLES = vro_pkg::LOSS_CYCLES
) (
   // system clock, reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // link side, on link clock
   input  wire logic        link_clk,
   input  wire logic [23:0] in_even,
   input  wire logic [23:0] in_odd,
   input  wire logic        in_de,
   input  wire logic        in_hsync,
   input  wire logic        in_vsync,
   input  wire logic        in_aux_control_first,
   input  wire logic        in_aux_control_second,
   input  wire logic        in_aux_control_third,
   output logic             in_take,
   // asynchronous pins
   input  wire logic        chip_powerdown_n,
   input  wire logic        output_powerdown_n,
   input  wire logic        clock_polarity_sel,
   // pixel outputs
   output logic      [23:0] even_pixel_bus,
   output logic      [23:0] odd_pixel_bus,
   output logic             pixel_out_clock,
   output logic             active_video_flag,
   output logic             hsync_out,
   output logic             vsync_out,
   output logic             aux_control_first,
   output logic             aux_control_second,
   output logic             aux_control_third,
   output logic             outputs_oe,
   output logic             aux_control_first_oe,
   output logic             link_alive_flag
);

   typedef struct packed {
      logic [1:0]  cpd;
      logic [1:0]  opd;
      logic [1:0]  pol;
      logic [1:0]  swpd;
      logic        phase;
      logic        ock;
      logic        take;
      logic [23:0] even;
      logic [23:0] odd;
      logic        de;
      logic        de_raw;
      logic        hs;
      logic        vs;
      logic        c1;
      logic        c2;
      logic        c3;
      logic        oe_main;
      logic        oe_c1;
   } vro_pix_st_t;

   typedef struct packed {
      logic [2:0]  stat1;
      logic [2:0]  stat2;
      logic        swpd;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } vro_ref_st_t;

   vro_pix_st_t px_q;
   vro_pix_st_t px_d;
   vro_ref_st_t rf_q;
   vro_ref_st_t rf_d;
   logic [1:0]  rrst_q;
   logic [1:0]  prst_q;
   logic        rst_n;
   logic        pix_rst_n;
   logic        pd_ok;
   logic        cpd_ok;
   logic        phase_d;
   logic        access;
   logic [2:0]  stat_src;
   vro_alive_if alive_bus ();

   // =======================================================
   // reset release in both domains
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rrst_q <= 2'h0;
      end else begin
         rrst_q <= {rrst_q[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         prst_q <= 2'h0;
      end else begin
         prst_q <= {prst_q[0], 1'b1};
      end
   end

   assign rst_n     = rrst_q[1];
   assign pix_rst_n = prst_q[1];

   // =======================================================
   // link domain: pixel capture, clock, drivers
   always_comb begin
      px_d      = px_q;
      px_d.cpd  = {px_q.cpd[0], chip_powerdown_n};
      px_d.opd  = {px_q.opd[0], output_powerdown_n};
      px_d.pol  = {px_q.pol[0], clock_polarity_sel};
      px_d.swpd = {px_q.swpd[0], rf_q.swpd};
      cpd_ok    = px_q.cpd[1];
      pd_ok     = px_q.cpd[1] & px_q.opd[1] & ~px_q.swpd[1];
      phase_d   = ~px_q.phase;
      px_d.phase = phase_d;
      px_d.take  = phase_d & cpd_ok;
      // main group enables drop at once, return on a boundary
      px_d.oe_main = pd_ok & (px_q.oe_main | phase_d);
      // first control line obeys chip power-down only
      px_d.oe_c1 = cpd_ok & (px_q.oe_c1 | phase_d);
      // clock follows phase; polarity touches nothing else
      px_d.ock = px_d.oe_main & (phase_d ^ px_q.pol[1]);
      if (!cpd_ok) begin
         px_d.de_raw = 1'b0;
      end else if (phase_d) begin
         px_d.de_raw = in_de;
      end
      if (!pd_ok) begin
         px_d.even = 24'h000000;
         px_d.odd  = 24'h000000;
         px_d.de   = 1'b0;
         px_d.hs   = 1'b0;
         px_d.vs   = 1'b0;
         px_d.c2   = 1'b0;
         px_d.c3   = 1'b0;
      end else if (phase_d) begin
         // new word on the normal rising edge, sampled mid-cycle
         px_d.even = in_even;
         px_d.odd  = in_odd;
         px_d.de   = in_de;
         px_d.hs   = in_hsync;
         px_d.vs   = in_vsync;
         px_d.c2   = in_aux_control_second;
         px_d.c3   = in_aux_control_third;
      end
      if (!cpd_ok) begin
         px_d.c1 = 1'b0;
      end else if (phase_d) begin
         px_d.c1 = in_aux_control_first;
      end
   end

   always_ff @(posedge link_clk or negedge pix_rst_n) begin
      if (!pix_rst_n) begin
         px_q <= '0;
      end else begin
         px_q <= px_d;
      end
   end

   assign alive_bus.de = px_q.de_raw;

   vro_alive_det #(
      .LOSS_CYCLES (LOSS_CYCLES)
   ) u_alive (
      .clk   (link_clk),
      .rst_n (pix_rst_n),
      .bus   (alive_bus)
   );

   assign even_pixel_bus       = px_q.even;
   assign odd_pixel_bus        = px_q.odd;
   assign pixel_out_clock      = px_q.ock;
   assign active_video_flag    = px_q.de;
   assign hsync_out            = px_q.hs;
   assign vsync_out            = px_q.vs;
   assign aux_control_first    = px_q.c1;
   assign aux_control_second   = px_q.c2;
   assign aux_control_third    = px_q.c3;
   assign outputs_oe           = px_q.oe_main;
   assign aux_control_first_oe = px_q.oe_c1;
   assign link_alive_flag      = alive_bus.alive;
   assign in_take              = px_q.take;

   // =======================================================
   // system domain: apb registers
   assign stat_src = {~px_q.oe_main, ~px_q.cpd[1], alive_bus.alive};
   assign access   = psel & penable;

   always_comb begin
      rf_d       = rf_q;
      rf_d.stat1 = stat_src;
      rf_d.stat2 = rf_q.stat1;
      if (access && !rf_q.pready) begin
         rf_d.pready  = 1'b1;
         rf_d.pslverr = 1'b0;
         rf_d.prdata  = 32'h00000000;
         if (paddr == vro_pkg::CTRL_OFF) begin
            if (!pwrite) begin
               rf_d.prdata[vro_pkg::CTRL_SWPD_BIT] = rf_q.swpd;
            end
         end else if (paddr == vro_pkg::STAT_OFF) begin
            if (!pwrite) begin
               rf_d.prdata[2:0] = rf_q.stat2;
            end
         end else begin
            rf_d.pslverr = 1'b1;
         end
      end else begin
         rf_d.pready  = 1'b0;
         rf_d.pslverr = 1'b0;
      end
      if (access && rf_q.pready && pwrite &&
          paddr == vro_pkg::CTRL_OFF) begin
         rf_d.swpd = pwdata[vro_pkg::CTRL_SWPD_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_q      <= '0;
         rf_q.swpd <= vro_pkg::CTRL_SWPD_RST;
      end else begin
         rf_q <= rf_d;
      end
   end

   assign prdata  = rf_q.prdata;
   assign pready  = rf_q.pready;
   assign pslverr = rf_q.pslverr;

   // =======================================================
   // checks
   a_bus_float_pd: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      !(px_q.cpd[1] && px_q.opd[1]) |=> !px_q.oe_main)
      else $error("pixel drivers not floated in power-down");

   a_float_low: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      !px_q.oe_main |-> px_q.even == 24'h000000 && !px_q.ock)
      else $error("floated outputs not held low");

   a_clk_polarity: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      (px_q.phase && px_q.oe_main) |-> px_q.ock != $past(px_q.pol[1]))
      else $error("output clock polarity wrong");

   a_data_on_edge: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      $changed(px_q.odd) |-> px_q.phase || !px_q.oe_main)
      else $error("pixel word changed off the clock boundary");

   a_flag_follows: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      (px_q.phase && px_q.oe_main && $past(px_q.oe_main))
      |-> px_q.de == $past(in_de))
      else $error("active-video flag not aligned with data");

   a_aux_control_first_kept: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      (px_q.cpd[1] && px_q.oe_c1) |=> px_q.oe_c1)
      else $error("first control floated without chip power-down");

   a_aux_control_first_float: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      !px_q.cpd[1] |=> !px_q.oe_c1 && !px_q.c1)
      else $error("first control driven in chip power-down");

   a_resume_edge: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      $rose(px_q.oe_main) |->
         px_q.phase && px_q.ock != $past(px_q.pol[1]))
      else $error("outputs resumed off a clock boundary");

   a_inputs_off: assert property (@(posedge link_clk)
      disable iff (!pix_rst_n)
      !px_q.cpd[1] |=> !px_q.take && !px_q.de_raw)
      else $error("inputs accepted in chip power-down");

   a_apb_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (access && !pready) |=> pready ##1 !pready)
      else $error("apb answer not one cycle after access");

endmodule // vro_out_port

// ==== verif/vro_sink.sv ====
// display-side model sampling the pixel outputs
`timescale 1ns/100ps
module vro_sink (
   // pixel side
   input  wire logic [23:0] even_pixel_bus,
   input  wire logic [23:0] odd_pixel_bus,
   input  wire logic        pixel_out_clock,
   input  wire logic        active_video_flag,
   input  wire logic        hsync_out,
   input  wire logic        vsync_out,
   input  wire logic        aux_control_first,
   input  wire logic        aux_control_second,
   input  wire logic        aux_control_third,
   input  wire logic        outputs_oe,
   input  wire logic        clock_polarity_sel,
   // expectation and tallies
   input  wire logic [53:0] exp_word,
   output int               samples,
   output int               bad
);
   logic [53:0] got;
   logic        oe_seen;

   // =======================================================
   // capture on the edge chosen by polarity
   initial begin
      samples = 0;
      bad = 0;
      oe_seen = 1'b0;
   end
   always @(negedge outputs_oe) begin
      oe_seen = 1'b0;
   end
   // let the edge's own updates settle before looking
   always @(pixel_out_clock) begin
      #1;
      if (pixel_out_clock === clock_polarity_sel &&
          outputs_oe === 1'b1) begin
         got = {even_pixel_bus, odd_pixel_bus, active_video_flag, hsync_out,
                vsync_out, aux_control_first, aux_control_second,
                aux_control_third};
         if (oe_seen) begin
            samples++;
            if (got !== exp_word) begin
               bad++;
               $display("BAD pixel_word expected %h seen %h", exp_word, got);
            end
         end
         oe_seen = 1'b1;
      end
   end
endmodule // vro_sink

// ==== verif/video_receiver_output_port_tb.sv ====
// testbench for the video receiver output port
`timescale 1ns/100ps
module video_receiver_output_port_tb;
   logic        ref_clk, link_clk, arst_n, psel, penable, pwrite, pready;
   logic        pslverr, in_de, in_hsync, in_vsync, in_aux_control_first, in_aux_control_second;
   logic        in_aux_control_third, in_take, chip_powerdown_n, output_powerdown_n;
   logic        clock_polarity_sel, pixel_out_clock, active_video_flag;
   logic        hsync_out, vsync_out, aux_control_first, aux_control_second;
   logic        aux_control_third, outputs_oe, aux_control_first_oe;
   logic        link_alive_flag, de_hold, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] in_even, in_odd, even_pixel_bus, odd_pixel_bus;
   logic [53:0] exp_word;
   int          num_errors, checks_done, seed, samples, bad;

   // =======================================================
   // design and display model
   vro_out_port #(.LOSS_CYCLES(22'd64)) vro_out_port_inst (.ref_clk,
      .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .link_clk, .in_even, .in_odd, .in_de, .in_hsync, .in_vsync,
      .in_aux_control_first, .in_aux_control_second, .in_aux_control_third, .in_take, .chip_powerdown_n,
      .output_powerdown_n, .clock_polarity_sel, .even_pixel_bus,
      .odd_pixel_bus, .pixel_out_clock, .active_video_flag, .hsync_out,
      .vsync_out, .aux_control_first, .aux_control_second,
      .aux_control_third, .outputs_oe, .aux_control_first_oe,
      .link_alive_flag);
   vro_sink vro_sink_inst (.even_pixel_bus, .odd_pixel_bus, .pixel_out_clock,
      .active_video_flag, .hsync_out, .vsync_out, .aux_control_first,
      .aux_control_second, .aux_control_third, .outputs_oe,
      .clock_polarity_sel, .exp_word, .samples, .bad);

   // =======================================================
   // clocks, watchdog
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   initial begin
      #200000;
      num_errors++;
      summarize;
   end

   // =======================================================
   // helpers
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (e !== g) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task lw(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // waits for pready; only the watchdog ends it if pready never rises
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // expected display word: the source word the port just captured
   function automatic logic [53:0] word_now();
      return {in_even, in_odd, in_de, in_hsync, in_vsync, in_aux_control_first, in_aux_control_second,
              in_aux_control_third};
   endfunction
   task summarize;
      num_errors += bad;
      checks_done += samples;
      if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // =======================================================
   // link source: new random word after each capture
   always @(posedge link_clk) begin
      if (in_take === 1'b1) begin
         exp_word = word_now();
         in_even <= 24'($random(seed));
         in_odd <= 24'($random(seed));
         in_de <= de_hold ? 1'b0 : 1'($random(seed));
         {in_hsync, in_vsync, in_aux_control_first, in_aux_control_second, in_aux_control_third} <= 5'($random(seed));
      end
   end

   // =======================================================
   // main sequence
   initial begin
      seed = 69;
      {arst_n, psel, penable, pwrite, de_hold, clock_polarity_sel} = '0;
      {paddr, pwdata, in_even, in_odd, exp_word} = '0;
      {in_de, in_hsync, in_vsync, in_aux_control_first, in_aux_control_second, in_aux_control_third} = '0;
      chip_powerdown_n = 1'b1;
      output_powerdown_n = 1'b1;
      repeat (3) @(posedge link_clk);
      arst_n <= 1'b1;
      lw(10);
      apb(1'b0, vro_pkg::CTRL_OFF, 32'h0);
      chk("ctrl_reset", 64'(vro_pkg::CTRL_SWPD_RST), 64'(rd[0]));
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped_err", 64'h1, 64'(er));
      chk("unmapped_data", 64'h0, 64'(rd));
      lw(400);
      chk("alive_up", 64'h1, 64'(link_alive_flag));
      apb(1'b0, vro_pkg::STAT_OFF, 32'h0);
      chk("stat_alive", 64'h1, 64'(rd[vro_pkg::STAT_ALIVE_BIT]));
      lw(1);
      de_hold <= 1'b1;
      lw(200);
      chk("alive_down", 64'h0, 64'(link_alive_flag));
      de_hold <= 1'b0;
      lw(400);
      output_powerdown_n <= 1'b0;
      lw(8);
      chk("oe_pdo", 64'h0, 64'(outputs_oe));
      chk("float_low", 64'h0, 64'({even_pixel_bus, odd_pixel_bus,
          pixel_out_clock, active_video_flag, hsync_out, vsync_out,
          aux_control_second, aux_control_third}));
      chk("aux_control_first_oe_pdo", 64'h1, 64'(aux_control_first_oe));
      chk("alive_pdo", 64'h1, 64'(link_alive_flag));
      clock_polarity_sel <= 1'b1;
      output_powerdown_n <= 1'b1;
      lw(8);
      chk("oe_resume", 64'h1, 64'(outputs_oe));
      lw(200);
      apb(1'b1, vro_pkg::CTRL_OFF, 32'h1);
      lw(8);
      chk("oe_sw", 64'h0, 64'(outputs_oe));
      apb(1'b0, vro_pkg::CTRL_OFF, 32'h0);
      chk("ctrl_back", 64'h1, 64'(rd[vro_pkg::CTRL_SWPD_BIT]));
      apb(1'b0, vro_pkg::STAT_OFF, 32'h0);
      chk("stat_float", 64'h1, 64'(rd[vro_pkg::STAT_FLOAT_BIT]));
      apb(1'b1, vro_pkg::CTRL_OFF, 32'h0);
      chip_powerdown_n <= 1'b0;
      lw(8);
      chk("oe_cpd", 64'h0, 64'(outputs_oe));
      chk("aux_control_first_oe_cpd", 64'h0, 64'(aux_control_first_oe));
      repeat (6) begin
         lw(1);
         chk("take_cpd", 64'h0, 64'(in_take));
      end
      apb(1'b0, vro_pkg::STAT_OFF, 32'h0);
      chk("stat_cpd", 64'h1, 64'(rd[vro_pkg::STAT_CPD_BIT]));
      clock_polarity_sel <= 1'b0;
      chip_powerdown_n <= 1'b1;
      lw(8);
      chk("oe_back", 64'h1, 64'(outputs_oe));
      lw(100);
      chk("sink_samples", 64'h1, 64'(samples > 200));
      summarize;
   end
endmodule // video_receiver_output_port_tb
